//--- design/lcsd_decoder.sv
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/10ps
module lcsd_decoder (
   // clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      rst_b,
   // avalon-mm slave
   input  wire logic [15:0]               avs_address,
   input  wire logic                      avs_read,
   input  wire logic                      avs_write,
   input  wire logic [31:0]               avs_writedata,
   input  wire logic [3:0]                avs_byteenable,
   output logic      [31:0]               avs_readdata,
   output logic                           avs_waitrequest,
   output logic      [1:0]                avs_response,
   // downstream cycle in
   input  wire logic                      cyc_valid,
   input  wire logic                      cyc_is_mem,
   input  wire logic                      cyc_is_read,
   input  wire logic [31:0]               cyc_addr,
   input  wire logic [3:0]                cyc_byte_en,
   // decode result
   output logic                           dec_valid,
   output lcsd_pkg::lcsd_target_type      dec_target,
   output logic      [15:0]               dec_dest_id,
   output logic                           dec_trapped
);
   import lcsd_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      lcsd_bus_state_type bus_state;
      logic               waitrequest;
      logic [31:0]        readdata;
      logic [1:0]         response;
      logic [3:0][31:0]   gio;
      logic [31:0]        gmem;
      logic [31:0]        flash;
      logic [31:0]        general_control_status;
      logic [31:0]        trap_low;
      logic [31:0]        trap_high;
      logic [31:0]        leg_range;
      logic [31:0]        io_enable;
      logic               sec_lock;
      logic [3:0]         trap_stat;
      logic               dec_valid;
      lcsd_target_type    dec_target;
      logic [15:0]        dec_dest_id;
      logic               dec_trapped;
   } lcsd_state_type;

   lcsd_state_type st;
   lcsd_state_type next_st;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [31:0] wmask, input logic [3:0] be);
      logic [31:0] lanes;
      lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
      return (old_v & ~lanes) | (new_v & lanes);
   endfunction : merge

   function automatic logic dw_match(input logic [31:0] cfg, input logic [15:0] a);
      logic [15:0] care;
      care = {8'hff, ~cfg[23:18], 2'h0};
      return ((a & care) == (cfg[15:0] & care & 16'hfffc));
   endfunction : dw_match

   function automatic logic [15:0] serial_base(input logic [2:0] code);
      return SERIAL_BASE[code];
   endfunction : serial_base

   function automatic logic in_eight(input logic [15:0] a, input logic [15:0] base);
      return (a[15:3] == base[15:3]);
   endfunction : in_eight

   function automatic logic reg_known(input logic [15:0] a);
      return (a == ADR_LINK_CTRL) || (a == ADR_FLASH) || (a == ADR_GMEM) || (a == ADR_GCS) ||
             (a == ADR_TRAP_LOW) || (a == ADR_TRAP_HIGH) || (a == ADR_LEG_RANGE) ||
             (a == ADR_IO_ENABLE) || (a == ADR_TRAP_STAT) || (a[15:4] == ADR_GIO_ONE[15:4]);
   endfunction : reg_known

   function automatic logic [31:0] read_word(input lcsd_state_type s, input logic [15:0] a);
      logic [31:0] w;
      w = 32'h0;
      if (a == ADR_LINK_CTRL) w[SEC_LOCK_BIT] = s.sec_lock;
      else if (a == ADR_FLASH) w = s.flash;
      else if (a == ADR_GMEM) w = s.gmem;
      else if (a == ADR_GCS) w = s.general_control_status;
      else if (a == ADR_TRAP_LOW) w = s.trap_low;
      else if (a == ADR_TRAP_HIGH) w = s.trap_high;
      else if (a == ADR_LEG_RANGE) w = s.leg_range;
      else if (a == ADR_IO_ENABLE) w = s.io_enable;
      else if (a == ADR_TRAP_STAT) w[3:0] = s.trap_stat;
      else if (a[15:4] == ADR_GIO_ONE[15:4]) w = s.gio[a[3:2]];
      return w;
   endfunction : read_word

   // ----------------------------------------------------------------
   // decode terms
   // ----------------------------------------------------------------
   logic [15:0] io_a;
   logic [11:0] seg_hi;
   logic        flash_hit;
   logic        gmem_hit;
   logic        post_hit;
   logic        alias_hit;
   logic        legacy_io_hit;
   logic        gio_hit;
   logic        trap_hit;
   logic        locked;
   logic        prn_hit;
   logic        fdd_hit;
   logic [15:0] fdd_base;
   logic [15:0] prn_base;

   always_comb begin
      io_a     = cyc_addr[15:0];
      seg_hi   = cyc_addr[31:20];
      locked   = st.sec_lock;
      // flash segments, data then feature space 4MB lower
      flash_hit = 1'b0;
      if (seg_hi == SEG512_TOP || seg_hi == SEG512_TOP - FEAT_OFFSET) begin
         if (cyc_addr[19] || st.flash[15]) flash_hit = cyc_addr[19] | flash_hit;
         if (!cyc_addr[19]) flash_hit = st.flash[14];
      end
      for (int i = 0; i < 3; i++) begin
         if (seg_hi == SEG512_TOP - 12'(i + 1) ||
             seg_hi == SEG512_TOP - FEAT_OFFSET - 12'(i + 1)) begin
            flash_hit = st.flash[13 - 2 * i - (cyc_addr[19] ? 0 : 1)];
         end
      end
      for (int i = 0; i < 4; i++) begin
         if (seg_hi == SEG1M_DATA + 12'(i) || seg_hi == SEG1M_FEAT + 12'(i)) begin
            flash_hit = st.flash[i];
         end
      end
      if (cyc_addr[31:16] == LEGACY_F_BLOCK) flash_hit = st.flash[LEGACY_F_BIT];
      if (cyc_addr[31:16] == LEGACY_E_BLOCK) flash_hit = st.flash[LEGACY_E_BIT];
      gmem_hit = st.gmem[0] && (cyc_addr[31:16] == st.gmem[31:16]);
      // io windows
      post_hit  = (io_a[15:4] == POST_BASE[15:4]);
      alias_hit = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (io_a == ALIAS_PORT[i]) alias_hit = 1'b1;
      end
      gio_hit = 1'b0;
      for (int i = 0; i < 4; i++) begin
         if (st.gio[i][GIO_ENABLE_BIT] && dw_match(st.gio[i], io_a)) gio_hit = 1'b1;
      end
      fdd_base = st.leg_range[FLOPPY_BIT] ? FLOPPY_SEC : FLOPPY_PRI;
      fdd_hit  = in_eight(io_a, fdd_base) && (io_a[2:0] != FLOPPY_GAP[2:0]);
      case (st.leg_range[9:8])
         2'h0: prn_base = PRN_STD;
         2'h1: prn_base = PRN_ALT;
         default: prn_base = PRN_NARROW;
      endcase
      prn_hit = (st.leg_range[9:8] != 2'h3) &&
                (in_eight(io_a, prn_base) || in_eight(io_a, prn_base + PRN_HIGH_OFS));
      if (st.leg_range[9:8] == 2'h2) begin
         prn_hit = prn_hit && (io_a[2:0] >= PRN_NARROW[2:0]) &&
                   (io_a[2:0] <= PRN_NARROW_END[2:0]);
      end
      if (st.leg_range[9:8] == 2'h1 && io_a == PRN_RO_PORT) prn_hit = prn_hit && cyc_is_read;
      legacy_io_hit =
         (st.io_enable[0] && in_eight(io_a, serial_base(st.leg_range[2:0]))) ||
         (st.io_enable[1] && in_eight(io_a, serial_base(st.leg_range[6:4]))) ||
         (st.io_enable[2] && prn_hit) || (st.io_enable[3] && fdd_hit) ||
         (st.io_enable[8] && in_eight(io_a, GAME_LOW)) ||
         (st.io_enable[9] && in_eight(io_a, GAME_HIGH));
      // trap comparator
      trap_hit = st.trap_low[TRAP_ENABLE_BIT] && dw_match(st.trap_low, io_a) &&
                 (st.trap_high[DIR_MASK_BIT] ||
                  (cyc_is_read == st.trap_high[DIR_VALUE_BIT])) &&
                 (((cyc_byte_en ^ st.trap_high[3:0]) & ~st.trap_high[7:4]) == 4'h0);
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st             = st;
      next_st.dec_valid   = 1'b0;
      next_st.dec_trapped = 1'b0;
      next_st.dec_target  = LCSD_DEFAULT;
      next_st.dec_dest_id = 16'h0000;
      // decode pipeline
      if (cyc_valid) begin
         next_st.dec_valid = 1'b1;
         if (cyc_is_mem) begin
            if (flash_hit) begin
               next_st.dec_target = st.general_control_status[BOOT_SEL_BIT] ? LCSD_ESPI : LCSD_SPI;
            end else if (gmem_hit) begin
               next_st.dec_target = LCSD_ESPI;
            end
         end else begin
            if (alias_hit) begin
               next_st.dec_target = LCSD_DEFAULT;
            end else if (post_hit) begin
               if (st.general_control_status[POST_ROUTE_BIT]) begin
                  next_st.dec_target  = LCSD_ROOT_PORT;
                  next_st.dec_dest_id = st.general_control_status[31:16];
               end
            end else if (gio_hit || legacy_io_hit) begin
               next_st.dec_target = LCSD_ESPI;
            end
            next_st.dec_trapped = trap_hit;
            if (trap_hit) next_st.trap_stat[0] = 1'b1;
         end
      end
      // register bus
      next_st.response = RESP_OKAY;
      case (st.bus_state)
         LCSD_IDLE: begin
            // read word and answer stand with the ack
            if (avs_read || avs_write) begin
               next_st.bus_state = LCSD_ACK;
               if (!reg_known(avs_address)) next_st.response = RESP_UNMAPPED;
               else if (avs_read) next_st.readdata = read_word(st, avs_address);
            end
         end
         default: begin
            next_st.bus_state = LCSD_IDLE;
            next_st.readdata  = 32'h0;
            if (avs_write) begin
               if (avs_address == ADR_LINK_CTRL) begin
                  if (avs_byteenable[3] && avs_writedata[SEC_LOCK_BIT]) next_st.sec_lock = 1'b1;
               end else if (avs_address == ADR_FLASH) begin
                  if (!locked) next_st.flash = merge(st.flash, avs_writedata, WM_FLASH,
                                                     avs_byteenable);
               end else if (avs_address == ADR_GMEM) begin
                  if (!locked) next_st.gmem = merge(st.gmem, avs_writedata, WM_GMEM,
                                                    avs_byteenable);
               end else if (avs_address == ADR_GCS) begin
                  if (!locked) next_st.general_control_status = merge(st.general_control_status, avs_writedata, WM_GCS_ROUTE,
                                                   avs_byteenable);
                  if (!locked && !st.general_control_status[LOCKDOWN_BIT] && avs_byteenable[1])
                     next_st.general_control_status[BOOT_SEL_BIT] = avs_writedata[BOOT_SEL_BIT];
                  if (avs_byteenable[0] && avs_writedata[LOCKDOWN_BIT])
                     next_st.general_control_status[LOCKDOWN_BIT] = 1'b1;
               end else if (avs_address == ADR_TRAP_LOW) begin
                  next_st.trap_low = merge(st.trap_low, avs_writedata, WM_TRAP_LOW, avs_byteenable);
               end else if (avs_address == ADR_TRAP_HIGH) begin
                  next_st.trap_high = merge(st.trap_high, avs_writedata, WM_TRAP_HIGH,
                                            avs_byteenable);
               end else if (avs_address == ADR_LEG_RANGE) begin
                  if (!locked) next_st.leg_range = merge(st.leg_range, avs_writedata,
                                                         WM_LEG_RANGE, avs_byteenable);
               end else if (avs_address == ADR_IO_ENABLE) begin
                  if (!locked) next_st.io_enable = merge(st.io_enable, avs_writedata,
                                                         WM_IO_ENABLE, avs_byteenable);
               end else if (avs_address == ADR_TRAP_STAT) begin
                  // set wins over clear
                  if (avs_byteenable[0] && !(cyc_valid && !cyc_is_mem && trap_hit))
                     next_st.trap_stat = st.trap_stat & ~avs_writedata[3:0];
                  else if (avs_byteenable[0])
                     next_st.trap_stat = (st.trap_stat & ~avs_writedata[3:0]) | 4'h1;
               end else if (avs_address[15:4] == ADR_GIO_ONE[15:4] &&
                            avs_address[3:2] <= ADR_GIO_FOUR[3:2]) begin
                  if (!locked) next_st.gio[avs_address[3:2]] =
                     merge(st.gio[avs_address[3:2]], avs_writedata, WM_GIO,
                           avs_byteenable);
               end
            end
         end
      endcase
      next_st.waitrequest = (next_st.bus_state != LCSD_ACK);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st           <= '0;
         st.flash     <= RST_FLASH;
         st.bus_state <= LCSD_IDLE;
         st.waitrequest <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign avs_readdata    = st.readdata;
   assign avs_response    = st.response;
   assign avs_waitrequest = st.waitrequest;
   assign dec_valid       = st.dec_valid;
   assign dec_target      = st.dec_target;
   assign dec_dest_id     = st.dec_dest_id;
   assign dec_trapped     = st.dec_trapped;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_lock_set;
      st.sec_lock;
   endsequence

   a_lock_sticky : assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_lock_set |=> st.sec_lock) else $error("secure lock dropped");
   a_flash_frozen : assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_lock_set |=> $stable(st.flash)) else $error("flash enables changed under lock");
   a_top_segment : assert property (@(posedge sys_clk) disable iff (!rst_b)
      st.flash[15]) else $error("top segment enable not one");
   a_lockdown_once : assert property (@(posedge sys_clk) disable iff (!rst_b)
      st.general_control_status[LOCKDOWN_BIT] |=> st.general_control_status[LOCKDOWN_BIT]) else $error("lockdown cleared");
   a_boot_frozen : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (st.general_control_status[LOCKDOWN_BIT] || st.sec_lock) |=> $stable(st.general_control_status[BOOT_SEL_BIT]))
      else $error("boot target changed while locked");
   a_alias_default : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (cyc_valid && !cyc_is_mem && alias_hit) |=> dec_target == LCSD_DEFAULT)
      else $error("alias port decoded");
   a_post_route : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (cyc_valid && !cyc_is_mem && post_hit && !alias_hit && st.general_control_status[POST_ROUTE_BIT])
      |=> (dec_target == LCSD_ROOT_PORT && dec_dest_id == $past(st.general_control_status[31:16])))
      else $error("post code not routed");
   a_trap_status : assert property (@(posedge sys_clk) disable iff (!rst_b)
      dec_trapped |-> st.trap_stat[0]) else $error("trap status not set");
   a_bus_answer : assert property (@(posedge sys_clk) disable iff (!rst_b)
      (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest) else $error("bus no answer");

endmodule : lcsd_decoder

//--- inc/lcsd_pkg.sv
package lcsd_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [15:0] ADR_GIO_ONE   = 16'h2730;
   localparam logic [15:0] ADR_GIO_TWO   = 16'h2734;
   localparam logic [15:0] ADR_GIO_THREE = 16'h2738;
   localparam logic [15:0] ADR_GIO_FOUR  = 16'h273c;
   localparam logic [15:0] ADR_GMEM      = 16'h2740;
   localparam logic [15:0] ADR_FLASH     = 16'h2744;
   localparam logic [15:0] ADR_GCS       = 16'h274c;
   localparam logic [15:0] ADR_TRAP_LOW  = 16'h2750;
   localparam logic [15:0] ADR_TRAP_HIGH = 16'h2754;
   localparam logic [15:0] ADR_LEG_RANGE = 16'h2770;
   localparam logic [15:0] ADR_IO_ENABLE = 16'h2774;
   localparam logic [15:0] ADR_LINK_CTRL = 16'h2234;
   localparam logic [15:0] ADR_TRAP_STAT = 16'h2780;

   // ----------------------------------------------------------------
   // reset values and writable masks
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_FLASH     = 32'h0000ffcf;
   localparam logic [31:0] WM_FLASH      = 32'h00007fcf;
   localparam logic [31:0] WM_GIO        = 32'h00fcfffe;
   localparam logic [31:0] WM_GMEM       = 32'hffff0001;
   localparam logic [31:0] WM_GCS_ROUTE  = 32'hffff0800;
   localparam logic [31:0] WM_TRAP_LOW   = 32'h00fcfffd;
   localparam logic [31:0] WM_TRAP_HIGH  = 32'h000300ff;
   localparam logic [31:0] WM_LEG_RANGE  = 32'h00001377;
   localparam logic [31:0] WM_IO_ENABLE  = 32'h0000030f;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int GIO_ENABLE_BIT   = 1;
   localparam int TRAP_ENABLE_BIT  = 0;
   localparam int DIR_MASK_BIT     = 17;
   localparam int DIR_VALUE_BIT    = 16;
   localparam int POST_ROUTE_BIT   = 11;
   localparam int BOOT_SEL_BIT     = 10;
   localparam int LOCKDOWN_BIT     = 0;
   localparam int SEC_LOCK_BIT     = 31;
   localparam int FLOPPY_BIT       = 12;
   localparam int LEGACY_F_BIT     = 7;
   localparam int LEGACY_E_BIT     = 6;

   // ----------------------------------------------------------------
   // address constants and bus response codes
   // ----------------------------------------------------------------
   localparam logic [11:0] SEG512_TOP     = 12'hfff;
   localparam logic [11:0] FEAT_OFFSET    = 12'h004;
   localparam logic [15:0] LEGACY_F_BLOCK = 16'h000f;
   localparam logic [15:0] LEGACY_E_BLOCK = 16'h000e;
   localparam logic [15:0] POST_BASE      = 16'h0080;
   localparam logic [15:0] FLOPPY_PRI     = 16'h03f0;
   localparam logic [15:0] FLOPPY_SEC     = 16'h0370;
   localparam logic [15:0] FLOPPY_GAP     = 16'h0006;
   localparam logic [15:0] PRN_HIGH_OFS   = 16'h0400;
   localparam logic [15:0] GAME_LOW       = 16'h0200;
   localparam logic [15:0] GAME_HIGH      = 16'h0208;
   localparam logic [11:0] SEG1M_DATA     = 12'hff4;
   localparam logic [11:0] SEG1M_FEAT     = 12'hff0;
   localparam logic [15:0] PRN_STD        = 16'h0378;
   localparam logic [15:0] PRN_ALT        = 16'h0278;
   localparam logic [15:0] PRN_NARROW     = 16'h038c;
   localparam logic [15:0] PRN_NARROW_END = 16'h038e;
   localparam logic [15:0] PRN_RO_PORT    = 16'h0279;
   localparam logic [15:0] ALIAS_PORT [8] = '{16'h0090, 16'h0094, 16'h0095, 16'h0096,
                                              16'h0098, 16'h009c, 16'h009d, 16'h009e};
   localparam logic [15:0] SERIAL_BASE [8] = '{16'h03f8, 16'h02f8, 16'h0220, 16'h0228,
                                               16'h0238, 16'h02e8, 16'h0338, 16'h03e8};
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_UNMAPPED  = 2'h3;

   // ----------------------------------------------------------------
   // routing results and bus states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      LCSD_DEFAULT,
      LCSD_ESPI,
      LCSD_SPI,
      LCSD_ROOT_PORT
   } lcsd_target_type;

   typedef enum logic [1:0] {
      LCSD_IDLE,
      LCSD_ACK
   } lcsd_bus_state_type;

endpackage : lcsd_pkg

//--- test/lcsd_link_host.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// host link model: one downstream cycle per request
// ----------------------------------------------------------------
module lcsd_link_host (
   // clock
   input  wire logic        sys_clk,
   // request from bench
   input  wire logic        req,
   input  wire logic        req_mem,
   input  wire logic        req_rd,
   input  wire logic [31:0] req_addr,
   input  wire logic [3:0]  req_be,
   // downstream cycle out
   output logic             cyc_valid   = 1'b0,
   output logic             cyc_is_mem  = 1'b0,
   output logic             cyc_is_read = 1'b0,
   output logic      [31:0] cyc_addr    = 32'h0,
   output logic      [3:0]  cyc_byte_en = 4'h0
);
   // address and byte enables scramble between cycles so nothing stale decodes
   always_ff @(posedge sys_clk) begin
      cyc_valid <= req;
      if (req) begin
         cyc_is_mem  <= req_mem;
         cyc_is_read <= req_rd;
         cyc_addr    <= req_addr;
         cyc_byte_en <= req_be;
      end else begin
         cyc_addr    <= ~cyc_addr;
         cyc_byte_en <= ~cyc_byte_en;
      end
   end
endmodule : lcsd_link_host

//--- test/lcsd_decoder_test.sv
`timescale 1ns/10ps
module lcsd_decoder_test;
   import lcsd_pkg::*;
   logic            sys_clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [15:0]     avs_address = 16'h0, dec_dest_id, id;
   logic [31:0]     avs_writedata = 32'h0, avs_readdata, cyc_addr, q, req_addr = 32'h0;
   logic [3:0]      avs_byteenable = 4'hf, cyc_byte_en, req_be = 4'h0;
   logic            avs_waitrequest, dec_valid, dec_trapped, cyc_valid, cyc_is_mem, cyc_is_read;
   logic            req = 1'b0, req_mem = 1'b0, req_rd = 1'b0;
   logic [1:0]      avs_response, r;
   logic [31:0]     seed = 32'h5226;
   lcsd_target_type dec_target;
   int              fail_count = 0, check_count = 0;
   always #10 sys_clk = ~sys_clk;
   lcsd_decoder dut (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .cyc_valid(cyc_valid),
      .cyc_is_mem(cyc_is_mem), .cyc_is_read(cyc_is_read), .cyc_addr(cyc_addr),
      .cyc_byte_en(cyc_byte_en), .dec_valid(dec_valid), .dec_target(dec_target),
      .dec_dest_id(dec_dest_id), .dec_trapped(dec_trapped));
   lcsd_link_host host (.sys_clk(sys_clk), .req(req), .req_mem(req_mem), .req_rd(req_rd),
      .req_addr(req_addr), .req_be(req_be), .cyc_valid(cyc_valid), .cyc_is_mem(cyc_is_mem),
      .cyc_is_read(cyc_is_read), .cyc_addr(cyc_addr), .cyc_byte_en(cyc_byte_en));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [31:0] com_base(input logic [2:0] c);
      logic [15:0] t [0:7];
      t = '{16'h03f8, 16'h02f8, 16'h0220, 16'h0228, 16'h0238, 16'h02e8, 16'h0338, 16'h03e8};
      return {16'h0, t[c]};
   endfunction : com_base
   task check(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask : check
   task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      do begin @(posedge sys_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n == 20) begin
         fail_count++;
         results;
      end
      q = avs_readdata;
      r = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task dec(input logic m, rd, input logic [31:0] a, input logic [3:0] be,
            input lcsd_target_type et, input logic [15:0] ei, input logic tr);
      int n;
      n = 0;
      @(posedge sys_clk);
      req <= 1'b1;
      req_mem <= m;
      req_rd <= rd;
      req_addr <= a;
      req_be <= be;
      @(posedge sys_clk);
      req <= 1'b0;
      do begin @(posedge sys_clk); n++; end while (dec_valid !== 1'b1 && n < 8);
      if (n == 8) begin
         fail_count++;
         results;
      end
      check("dec_target", {29'h0, et}, {29'h0, dec_target});
      check("dec_dest_id", {16'h0, ei}, {16'h0, dec_dest_id});
      check("dec_trapped", {31'h0, tr}, {31'h0, dec_trapped});
   endtask : dec
   task results;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   initial begin
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      bus(0, ADR_FLASH, 0); check("flash", RST_FLASH, q);
      bus(0, 16'h2790, 0); check("response", 32'h3, {30'h0, r});
      seed = lfsr(seed);
      dec(1, 1, 32'hfff80000 | seed[18:0], 4'hf, LCSD_SPI, 0, 0);
      bus(1, ADR_GCS, 32'h400);
      dec(1, 1, 32'hfff00000 | seed[18:0], 4'hf, LCSD_ESPI, 0, 0);
      dec(1, 0, 32'hff000000 | seed[19:0], 4'hf, LCSD_ESPI, 0, 0);
      dec(1, 1, 32'h000f0000 | seed[15:0], 4'hf, LCSD_ESPI, 0, 0);
      bus(1, ADR_FLASH, 32'h0); bus(0, ADR_FLASH, 0); check("flash", 32'h8000, q);
      dec(1, 1, 32'hfff00000 | seed[18:0], 4'hf, LCSD_DEFAULT, 0, 0);
      dec(1, 1, 32'hfffc0000, 4'hf, LCSD_ESPI, 0, 0);
      dec(1, 1, 32'h000e0000 | seed[15:0], 4'hf, LCSD_DEFAULT, 0, 0);
      bus(1, ADR_GMEM, {1'b0, seed[30:16], 16'h1});
      dec(1, 1, {1'b0, seed[30:0]}, 4'hf, LCSD_ESPI, 0, 0);
      $display("test flash and memory windows done");
      id = 16'h1 << seed[3:0];
      bus(1, ADR_GCS, {id, 16'h0c00});
      dec(0, 0, 32'h80 | seed[3:0], 4'h1, LCSD_ROOT_PORT, id, 0);
      dec(0, 1, 32'h9c, 4'h1, LCSD_DEFAULT, 0, 0);
      bus(1, ADR_GCS, 32'h0400);
      dec(0, 0, 32'h85, 4'h1, LCSD_DEFAULT, 0, 0);
      for (int k = 0; k < 8; k++) begin
         bus(1, ADR_LEG_RANGE, {25'h0, k[2:0], 1'b0, k[2:0]});
         bus(1, ADR_IO_ENABLE, k[0] ? 32'h1 : 32'h2);
         seed = lfsr(seed);
         dec(0, seed[3], com_base(k[2:0]) | seed[2:0], 4'h1, LCSD_ESPI, 0, 0);
      end
      bus(1, ADR_LEG_RANGE, 32'h1200);
      bus(1, ADR_IO_ENABLE, 32'hc);
      dec(0, 1, 32'h377, 4'h1, LCSD_ESPI, 0, 0);
      dec(0, 1, 32'h376, 4'h1, LCSD_DEFAULT, 0, 0);
      dec(0, 0, 32'h38a, 4'h1, LCSD_DEFAULT, 0, 0);
      dec(0, 0, 32'h78d, 4'h1, LCSD_ESPI, 0, 0);
      bus(1, ADR_IO_ENABLE, 32'h0);
      dec(0, 1, com_base(3'h7), 4'h1, LCSD_DEFAULT, 0, 0);
      bus(1, ADR_GIO_THREE, 32'h000c02a2);
      dec(0, 0, 32'h2a0 | seed[3:0], 4'h1, LCSD_ESPI, 0, 0);
      dec(0, 0, 32'h2b0, 4'h1, LCSD_DEFAULT, 0, 0);
      $display("test io windows done");
      bus(1, ADR_TRAP_LOW, 32'h000c0381);
      bus(1, ADR_TRAP_HIGH, 32'h000100f0);
      dec(0, 1, 32'h38c, 4'h2, LCSD_DEFAULT, 0, 1);
      dec(0, 0, 32'h38c, 4'h2, LCSD_DEFAULT, 0, 0);
      dec(0, 1, 32'h390, 4'h1, LCSD_DEFAULT, 0, 0);
      bus(1, ADR_TRAP_LOW, 32'h000c0380);
      dec(0, 1, 32'h384, 4'h1, LCSD_DEFAULT, 0, 0);
      bus(0, ADR_TRAP_STAT, 0); check("trap_stat", 32'h1, q);
      bus(1, ADR_TRAP_STAT, 32'h1);
      bus(0, ADR_TRAP_STAT, 0); check("trap_stat", 32'h0, q);
      $display("test trap done");
      bus(1, ADR_GCS, 32'h401); bus(1, ADR_GCS, 32'h0);
      bus(0, ADR_GCS, 0); check("gcs", 32'h401, q);
      bus(1, ADR_LINK_CTRL, 32'h80000000); bus(1, ADR_FLASH, 32'h7fcf);
      bus(0, ADR_FLASH, 0); check("flash", 32'h8000, q);
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      bus(0, ADR_LINK_CTRL, 0); check("lock", 32'h0, q);
      bus(0, ADR_FLASH, 0); check("flash", RST_FLASH, q);
      $display("test locks done");
      results;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      results;
   end
endmodule : lcsd_decoder_test
